//--- src/quad_dac_readback_status.sv
// Serial readback path, register store and status word of the quad output converter
// How it works
// - A frame with its top bit set is a read request, not a write.
// - Request bits 22:21 are device address, 20:16 the selector, rest ignored.
// - Device address and selector together pick the register returned.
// - Selectors 0-15 return data, control, gain, offset registers, channels A-D.
// - Selectors 16-19 return clear codes, 20-23 slew registers, channels A-D.
// - Selector 24 status, 25 main control, 26 converter supply control.
// - The chosen register shifts out during the frame after the request.
// - No-operation word 0x1CE000 with address bits substituted writes no register.
// - Slew register: code 000 on top, bit 12 enable, 6:3 rate, 2:0 step.
// - Slew limiting is set up separately for each channel.
// - Status register is read-only; writes never change it.
// - Status bit 11 user toggle, 10 checksum error, 9 ramp, 8 over-temperature.
// - Bits 15:12 boost trouble D-A; in current mode current fault set too.
// - In voltage mode boost trouble flags a boost supply not regulating.
// - In voltage mode boost trouble alone never drives the fault alarm output.
// - With status autoshift set, every write frame not following a read request shifts out the status.
// - With autoshift clear, status is read through the two-frame readback.
// - Checksum error flag reflects the most recently received word.
// - Ramp flag set while a slew-enabled channel is still stepping.
// - User toggle flag changes only through a software register write.
module quad_dac_readback_status (
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic i_sclk,
  input wire logic i_sync_n,
  input wire logic i_sdin,
  input wire logic [1:0] i_dev_addr,
  input wire logic [3:0] i_boost_trouble,
  input wire logic [3:0] i_vout_fault,
  input wire logic [3:0] i_iout_fault,
  input wire logic i_over_temp,
  input wire logic [3:0] i_current_mode,
  input wire logic [3:0] i_chan_stepping,
  input wire logic i_pec_bad,
  output logic o_serial_out_pin,
  output logic [3:0] o_slew_limit_on,
  output logic o_fault_n
);
  import readback_pkg::*;

  typedef enum {S_IDLE, S_FETCH, S_LOAD} core_state_t;

  // ---------------------------------------------------------------
  // Link domain: shift in on falling edge, shift out on rising edge
  // ---------------------------------------------------------------
  logic link_rst_n;
  logic [4:0] in_cnt, next_in_cnt;
  logic [22:0] in_shift, next_in_shift;
  logic [23:0] rx_word, next_rx_word;
  logic rx_tog, next_rx_tog;
  logic [4:0] out_cnt, next_out_cnt;
  logic next_sdo;
  logic [23:0] tx_word;

  // Bit counters restart whenever the frame signal is inactive
  assign link_rst_n = i_arst_n & ~i_sync_n;

  always_comb begin
    next_in_shift = {in_shift[21:0], i_sdin};
    next_in_cnt = in_cnt;
    next_rx_word = rx_word;
    next_rx_tog = rx_tog;
    if (in_cnt < 5'(FRAME_BITS)) begin
      next_in_cnt = in_cnt + 5'h01;
    end
    if (in_cnt == LAST_BIT_IDX) begin
      next_rx_word = {in_shift, i_sdin};
      next_rx_tog = ~rx_tog;
    end
  end

  always_ff @(negedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      in_cnt <= 5'h00;
      in_shift <= 23'h000000;
    end else begin
      in_cnt <= next_in_cnt;
      in_shift <= next_in_shift;
    end
  end

  // Received word and its toggle survive the end of the frame
  always_ff @(negedge i_sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rx_word <= TX_RESET;
      rx_tog <= 1'b0;
    end else begin
      rx_word <= next_rx_word;
      rx_tog <= next_rx_tog;
    end
  end

  // tx_word is only changed by the core while no frame is active
  always_comb begin
    next_out_cnt = out_cnt;
    next_sdo = 1'b0;
    if (out_cnt < 5'(FRAME_BITS)) begin
      next_out_cnt = out_cnt + 5'h01;
      next_sdo = tx_word[LAST_BIT_IDX - out_cnt];
    end
  end

  always_ff @(posedge i_sclk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      out_cnt <= 5'h00;
      o_serial_out_pin <= 1'b0;
    end else begin
      out_cnt <= next_out_cnt;
      o_serial_out_pin <= next_sdo;
    end
  end

  // ---------------------------------------------------------------
  // Crossings into the core domain
  // ---------------------------------------------------------------
  logic [1:0] link_s;
  logic [14:0] pins_s;
  logic rx_tog_d;
  logic rx_ev;
  logic frame_idle;
  logic [1:0] dev_addr_s;
  logic [3:0] boost_s, vout_s, iout_s;
  logic otemp_s;

  bit_sync #(.W(2)) u_link_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async({rx_tog, i_sync_n}),
    .o_sync(link_s)
  );

  bit_sync #(.W(15)) u_pin_sync (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_async({i_dev_addr, i_boost_trouble, i_vout_fault, i_iout_fault, i_over_temp}),
    .o_sync(pins_s)
  );

  assign {dev_addr_s, boost_s, vout_s, iout_s, otemp_s} = pins_s;
  assign frame_idle = link_s[0];
  assign rx_ev = link_s[1] ^ rx_tog_d;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  logic for_us, is_read, is_nop, wr_ev, rd_ev;
  logic [4:0] rx_sel;
  logic [15:0] rx_data;

  assign rx_sel = rx_word[SEL_HI:SEL_LO];
  assign rx_data = rx_word[DATA_W-1:0];
  assign for_us = (rx_word[ADDR_HI:ADDR_LO] == dev_addr_s);
  assign is_read = rx_word[RW_BIT];
  assign is_nop = (rx_sel == SEL_NOP) && (rx_data == NOP_DATA);
  assign rd_ev = rx_ev && for_us && is_read;
  assign wr_ev = rx_ev && for_us && !is_read && !is_nop;

  function automatic logic slew_sel(input logic [4:0] sel);
    slew_sel = (sel >= SEL_SLEW_A) && (sel <= SEL_SLEW_D);
  endfunction : slew_sel

  // ---------------------------------------------------------------
  // Register store and per-channel slew enables
  // ---------------------------------------------------------------
  logic mem_we;
  logic [15:0] mem_wdata, mem_rdata;
  logic [4:0] rd_sel, next_rd_sel;
  logic [3:0] next_slew_on;
  logic user_toggle, next_user_toggle;
  logic autoshift, next_autoshift;
  logic pec_err, next_pec_err;

  always_comb begin
    mem_we = 1'b0;
    mem_wdata = rx_data;
    next_slew_on = o_slew_limit_on;
    next_user_toggle = user_toggle;
    next_autoshift = autoshift;
    next_pec_err = pec_err;
    if (rx_ev) begin
      next_pec_err = i_pec_bad;
    end
    if (wr_ev) begin
      if (slew_sel(rx_sel)) begin
        if (rx_data[SLEW_CODE_HI:SLEW_CODE_LO] == SLEW_CODE) begin
          mem_we = 1'b1;
          mem_wdata = rx_data & SLEW_KEEP_MASK;
          next_slew_on[rx_sel[1:0]] = rx_data[SLEW_ON_BIT];
        end
      end else if (rx_sel < SEL_STATUS || rx_sel == SEL_BOOST_CTRL) begin
        mem_we = 1'b1;
      end else if (rx_sel == SEL_MAIN) begin
        mem_we = 1'b1;
        next_autoshift = rx_data[AUTOSHIFT_BIT];
      end else if (rx_sel == SEL_SOFTWARE) begin
        next_user_toggle = rx_data[USER_TOGGLE_SW_BIT];
      end
    end
  end

  reg_mem #(.W(DATA_W), .DEPTH(32), .AW(5)) u_store (
    .i_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_we(mem_we),
    .i_waddr(rx_sel),
    .i_wdata(mem_wdata),
    .i_raddr(rd_sel),
    .o_rdata(mem_rdata)
  );

  // ---------------------------------------------------------------
  // Status word and fault alarm
  // ---------------------------------------------------------------
  logic [15:0] status, next_status;
  logic next_fault_n;

  always_comb begin
    next_status = STATUS_RESET;
    next_status[ST_BOOST_LO +: 4] = boost_s;
    next_status[ST_TOGGLE] = user_toggle;
    next_status[ST_PEC] = pec_err;
    next_status[ST_RAMP] = |(i_chan_stepping & o_slew_limit_on);
    next_status[ST_OTEMP] = otemp_s;
    next_status[ST_VOUT_LO +: 4] = vout_s;
    next_status[ST_IOUT_LO +: 4] = iout_s | (boost_s & i_current_mode);
    next_fault_n = ~(status[ST_OTEMP] | (|status[7:0]));
  end

  // ---------------------------------------------------------------
  // Readback sequencing
  // ---------------------------------------------------------------
  core_state_t state, next_state;
  logic rd_pend, next_rd_pend;
  logic [23:0] next_tx_word;

  always_comb begin
    next_state = state;
    next_rd_sel = rd_sel;
    next_rd_pend = rd_pend;
    next_tx_word = tx_word;
    case (state)
      S_IDLE: begin
        if (rd_ev) begin
          next_rd_sel = rx_sel;
          next_rd_pend = 1'b1;
          next_state = S_FETCH;
        end else if (rx_ev) begin
          next_rd_pend = 1'b0;
          next_state = S_LOAD;
        end else if (frame_idle && !rd_pend && autoshift) begin
          next_tx_word = {8'h00, status};
        end
      end
      S_FETCH: begin
        next_state = S_LOAD;
      end
      S_LOAD: begin
        if (frame_idle) begin
          next_state = S_IDLE;
          if (rd_pend) begin
            next_tx_word = {1'b0, dev_addr_s, rd_sel, mem_rdata};
            if (rd_sel == SEL_STATUS) begin
              next_tx_word[15:0] = status;
            end
          end else if (autoshift) begin
            next_tx_word = {8'h00, status};
          end else begin
            next_tx_word = TX_RESET;
          end
        end
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= S_IDLE;
      rd_sel <= SEL_DATA_A;
      rd_pend <= 1'b0;
      tx_word <= TX_RESET;
      rx_tog_d <= 1'b0;
      o_slew_limit_on <= 4'h0;
      user_toggle <= 1'b0;
      autoshift <= 1'b0;
      pec_err <= 1'b0;
      status <= STATUS_RESET;
      o_fault_n <= 1'b1;
    end else begin
      state <= next_state;
      rd_sel <= next_rd_sel;
      rd_pend <= next_rd_pend;
      tx_word <= next_tx_word;
      rx_tog_d <= link_s[1];
      o_slew_limit_on <= next_slew_on;
      user_toggle <= next_user_toggle;
      autoshift <= next_autoshift;
      pec_err <= next_pec_err;
      status <= next_status;
      o_fault_n <= next_fault_n;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_read_starts_fetch: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == S_IDLE && rd_ev) |=> (state == S_FETCH) ##1 (state == S_LOAD))
    else $error("read request did not start a fetch");
  a_nop_no_write: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (rx_ev && is_nop && !is_read) |-> !mem_we ##1 $stable(user_toggle))
    else $error("no-operation frame changed a register");
  a_status_ro: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (rx_ev && !is_read && rx_sel == SEL_STATUS) |-> !mem_we)
    else $error("write reached the status register");
  a_status_readback: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == S_LOAD && frame_idle && rd_pend && rd_sel == SEL_STATUS) |=> (tx_word[15:0] == $past(status)))
    else $error("status selector returned wrong word");
  a_autoshift_word: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (state == S_LOAD && frame_idle && !rd_pend && autoshift) |=> (tx_word == {8'h00, $past(status)}))
    else $error("autoshift did not load status");
  a_boost_no_alarm: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (status[ST_OTEMP] == 1'b0 && status[7:0] == 8'h00) |=> o_fault_n)
    else $error("alarm raised without a fault");
  a_ramp_flag: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    (|(i_chan_stepping & o_slew_limit_on)) |=> status[ST_RAMP])
    else $error("ramp flag missing while stepping");
  a_iout_follows: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    ((status[15:12] & $past(i_current_mode) & ~status[3:0]) == 4'h0))
    else $error("boost trouble in current mode without current fault");
  a_toggle_sw_only: assert property (@(posedge i_core_clk) disable iff (!i_arst_n)
    !(wr_ev && rx_sel == SEL_SOFTWARE) |=> $stable(user_toggle))
    else $error("user toggle changed without software write");
endmodule : quad_dac_readback_status

//--- src/readback_pkg.sv
// Shared constants of the readback and status register bank
package readback_pkg;
  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int RW_BIT = 23;
  localparam int ADDR_HI = 22;
  localparam int ADDR_LO = 21;
  localparam int SEL_HI = 20;
  localparam int SEL_LO = 16;
  localparam int DATA_W = 16;
  localparam logic [4:0] LAST_BIT_IDX = 5'h17;
  // ---------------------------------------------------------------
  // Register selectors
  // ---------------------------------------------------------------
  localparam logic [4:0] SEL_DATA_A = 5'h00;
  localparam logic [4:0] SEL_CTRL_A = 5'h04;
  localparam logic [4:0] SEL_GAIN_A = 5'h08;
  localparam logic [4:0] SEL_OFFS_A = 5'h0C;
  localparam logic [4:0] SEL_CLR_A = 5'h10;
  localparam logic [4:0] SEL_SLEW_A = 5'h14;
  localparam logic [4:0] SEL_SLEW_D = 5'h17;
  localparam logic [4:0] SEL_STATUS = 5'h18;
  localparam logic [4:0] SEL_MAIN = 5'h19;
  localparam logic [4:0] SEL_BOOST_CTRL = 5'h1A;
  localparam logic [4:0] SEL_SOFTWARE = 5'h1B;
  localparam logic [4:0] SEL_NOP = 5'h1C;
  localparam logic [15:0] NOP_DATA = 16'hE000;
  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int SLEW_CODE_HI = 15;
  localparam int SLEW_CODE_LO = 13;
  localparam logic [2:0] SLEW_CODE = 3'h0;
  localparam int SLEW_ON_BIT = 12;
  localparam logic [15:0] SLEW_KEEP_MASK = 16'h107F;
  localparam int AUTOSHIFT_BIT = 0;
  localparam int USER_TOGGLE_SW_BIT = 12;
  localparam int ST_BOOST_LO = 12;
  localparam int ST_TOGGLE = 11;
  localparam int ST_PEC = 10;
  localparam int ST_RAMP = 9;
  localparam int ST_OTEMP = 8;
  localparam int ST_VOUT_LO = 4;
  localparam int ST_IOUT_LO = 0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;
  localparam logic [23:0] TX_RESET = 24'h000000;
endpackage : readback_pkg

//--- src/bit_sync.sv
// Two flip-flop synchroniser for a group of independent levels
module bit_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);
  logic [W-1:0] stage1;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      stage1 <= '0;
      o_sync <= '0;
    end else begin
      stage1 <= i_async;
      o_sync <= stage1;
    end
  end
endmodule : bit_sync

//--- src/reg_mem.sv
// Small register memory with one write port and a registered read port
module reg_mem #(
  parameter int W = 16,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic i_we,
  input wire logic [AW-1:0] i_waddr,
  input wire logic [W-1:0] i_wdata,
  input wire logic [AW-1:0] i_raddr,
  output logic [W-1:0] o_rdata
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      for (int k = 0; k < DEPTH; k++) begin
        mem[k] <= '0;
      end
      o_rdata <= '0;
    end else begin
      if (i_we) begin
        mem[i_waddr] <= i_wdata;
      end
      o_rdata <= mem[i_raddr];
    end
  end
endmodule : reg_mem

//--- dv/spi_host_model.sv
// Host side serial master model driving the link of the register bank
module spi_host_model (
  output logic o_sclk,
  output logic o_sync_n,
  output logic o_sdin,
  input wire logic i_sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    o_sclk = 1'b0;
    o_sync_n = 1'b1;
    o_sdin = 1'b0;
  end

  // ---------------------------------------------------------------
  // One 24-bit frame, MSB first; clock stands still outside frames
  // ---------------------------------------------------------------
  task automatic xfer(input logic [23:0] w, output logic [23:0] got);
    o_sync_n = 1'b0;
    for (int k = 23; k >= 0; k--) begin
      o_sdin = w[k];
      #12 o_sclk = 1'b1;
      #16 o_sclk = 1'b0;
      got[k] = i_sdo;
      #4;
    end
    #12 o_sync_n = 1'b1;
    // Released data line must not keep showing the last bit
    o_sdin = ~o_sdin;
    #300;
  endtask : xfer

  // Request frame, then a no-operation frame that carries the answer
  task automatic rd(input logic [1:0] a, input logic [4:0] s, input logic [15:0] x, output logic [23:0] got);
    logic [23:0] dummy;
    xfer({1'b1, a, s, x}, dummy);
    xfer({1'b0, a, 5'h1C, 16'hE000}, got);
  endtask : rd
endmodule : spi_host_model

//--- dv/quad_dac_readback_status_test.sv
// Self-checking bench of the readback and status register bank
module quad_dac_readback_status_test;
  timeunit 1ns;
  timeprecision 1ps;
  import readback_pkg::*;

  logic i_core_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic i_sclk;
  logic i_sync_n;
  logic i_sdin;
  logic [1:0] i_dev_addr = 2'h1;
  logic [3:0] i_boost_trouble = 4'h0;
  logic [3:0] i_vout_fault = 4'h0;
  logic [3:0] i_iout_fault = 4'h0;
  logic i_over_temp = 1'b0;
  logic [3:0] i_current_mode = 4'h0;
  logic [3:0] i_chan_stepping = 4'h0;
  logic i_pec_bad = 1'b0;
  logic o_serial_out_pin;
  logic [3:0] o_slew_limit_on;
  logic o_fault_n;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;

  always #5 i_core_clk = ~i_core_clk;

  quad_dac_readback_status quad_dac_readback_status_i (
    .i_core_clk(i_core_clk),
    .i_arst_n(i_arst_n),
    .i_sclk(i_sclk),
    .i_sync_n(i_sync_n),
    .i_sdin(i_sdin),
    .i_dev_addr(i_dev_addr),
    .i_boost_trouble(i_boost_trouble),
    .i_vout_fault(i_vout_fault),
    .i_iout_fault(i_iout_fault),
    .i_over_temp(i_over_temp),
    .i_current_mode(i_current_mode),
    .i_chan_stepping(i_chan_stepping),
    .i_pec_bad(i_pec_bad),
    .o_serial_out_pin(o_serial_out_pin),
    .o_slew_limit_on(o_slew_limit_on),
    .o_fault_n(o_fault_n)
  );

  spi_host_model spi_host_model_i (
    .o_sclk(i_sclk),
    .o_sync_n(i_sync_n),
    .o_sdin(i_sdin),
    .i_sdo(o_serial_out_pin)
  );

  // ---------------------------------------------------------------
  // Shared helpers
  // ---------------------------------------------------------------
  task automatic wrap_up;
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [1:0] a, input logic [4:0] s, input logic [15:0] d);
    logic [23:0] g;
    spi_host_model_i.xfer({1'b0, a, s, d}, g);
  endtask : wr

  task automatic settle;
    repeat (10) @(negedge i_core_clk);
  endtask : settle

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_map;
    logic [23:0] g;
    logic [15:0] d;
    for (int s = 0; s < 24; s++) begin
      wr(2'h1, s[4:0], {3'h0, s[4:0], 8'hA5});
    end
    for (int s = 0; s < 24; s++) begin
      d = {3'h0, s[4:0], 8'hA5};
      if (s >= 20) d = d & SLEW_KEEP_MASK;
      spi_host_model_i.rd(2'h1, s[4:0], 16'hFFFF, g);
      chk(g, {3'h1, s[4:0], d});
    end
  endtask : t_map

  task automatic t_chain;
    logic [23:0] g;
    spi_host_model_i.xfer(24'hA80000, g);
    chk(g, 24'h0);
    spi_host_model_i.xfer(24'hA90000, g);
    chk(g, {3'h1, 5'h08, 16'h08A5});
    spi_host_model_i.xfer(24'h3CE000, g);
    chk(g, {3'h1, 5'h09, 16'h09A5});
  endtask : t_chain

  task automatic t_slew;
    logic [23:0] g;
    chk({20'h0, o_slew_limit_on}, 24'hF);
    wr(2'h1, 5'h15, 16'h0000);
    wr(2'h1, 5'h16, 16'h2000);
    chk({20'h0, o_slew_limit_on}, 24'hD);
    spi_host_model_i.rd(2'h1, 5'h16, 16'h0, g);
    chk(g, {3'h1, 5'h16, 16'h16A5 & SLEW_KEEP_MASK});
  endtask : t_slew

  task automatic t_status;
    logic [23:0] g;
    @(negedge i_core_clk);
    i_boost_trouble = 4'h5;
    i_chan_stepping = 4'h2;
    settle();
    spi_host_model_i.rd(2'h1, SEL_STATUS, 16'h0, g);
    chk(g, {3'h1, SEL_STATUS, 16'h5000});
    chk({23'h0, o_fault_n}, 24'h1);
    @(negedge i_core_clk);
    i_current_mode = 4'h1;
    i_chan_stepping = 4'h1;
    i_vout_fault = 4'h8;
    i_over_temp = 1'b1;
    settle();
    spi_host_model_i.rd(2'h1, SEL_STATUS, 16'h0, g);
    chk(g, {3'h1, SEL_STATUS, 16'h5381});
    chk({23'h0, o_fault_n}, 24'h0);
    wr(2'h1, SEL_SOFTWARE, 16'h1000);
    wr(2'h1, SEL_STATUS, 16'h0000);
    spi_host_model_i.rd(2'h1, SEL_STATUS, 16'h0, g);
    chk(g, {3'h1, SEL_STATUS, 16'h5B81});
  endtask : t_status

  task automatic t_auto;
    logic [23:0] g;
    wr(2'h1, SEL_MAIN, 16'h0001);
    @(negedge i_core_clk);
    i_pec_bad = 1'b1;
    spi_host_model_i.xfer({3'h1, 5'h0A, 16'h1234}, g);
    chk(g, {8'h00, 16'h5B81});
    @(negedge i_core_clk);
    i_pec_bad = 1'b0;
    spi_host_model_i.xfer(24'h3CE000, g);
    chk(g, {8'h00, 16'h5F81});
    spi_host_model_i.xfer({3'h1, SEL_MAIN, 16'h0000}, g);
    chk(g, {8'h00, 16'h5B81});
    spi_host_model_i.xfer(24'h3CE000, g);
    chk(g, 24'h0);
  endtask : t_auto

  task automatic t_other;
    logic [23:0] g;
    spi_host_model_i.rd(2'h2, 5'h08, 16'h0, g);
    chk(g, 24'h0);
    wr(2'h2, 5'h08, 16'hBEEF);
    spi_host_model_i.rd(2'h1, 5'h08, 16'h0, g);
    chk(g, {3'h1, 5'h08, 16'h08A5});
    @(negedge i_core_clk);
    i_iout_fault = 4'h4;
    i_dev_addr = 2'h0;
    settle();
    spi_host_model_i.rd(2'h0, SEL_STATUS, 16'h0, g);
    chk(g, {3'h0, SEL_STATUS, 16'h5B85});
    chk({23'h0, o_fault_n}, 24'h0);
    spi_host_model_i.rd(2'h1, 5'h08, 16'h0, g);
    chk(g, 24'h0);
  endtask : t_other

  initial begin
    repeat (5) @(negedge i_core_clk);
    chk({18'h0, o_fault_n, o_slew_limit_on, o_serial_out_pin}, 24'h20);
    i_arst_n = 1'b1;
    settle();
    t_map();
    t_chain();
    t_slew();
    t_status();
    t_auto();
    t_other();
    wrap_up();
  end
endmodule : quad_dac_readback_status_test
